/* bench/acm_prog_model.sv */
// programming tool model: issues stored-word writes through the pin decoder port
// assumes the bench calls write() and shares sys_clk_i with the mapper
`timescale 1ns/1ns
module acm_prog_model
  import acm_pkg::*;
(
  input  wire logic    sys_clk_i,
  output acm_prog_wr_t prog_wr_o
);
  initial prog_wr_o = '0;

  task automatic write(input logic [3:0] addr, input logic [15:0] data);
    logic [15:0] word;
    word = data;
    if (addr == 4'h9) word[2:0] = 3'h0;
    if (addr == 4'hA || addr == 4'hB) word[15:13] = 3'h0;
    // reserved limit codes are never sent
    if (addr == 4'hA && word < 16'h0100) return;
    if (addr == 4'hB && word > 16'h1300 && word < 16'h1401) return;
    @(posedge sys_clk_i);
    #5 prog_wr_o = '{en: 1'b1, addr: addr, data: word};
    @(posedge sys_clk_i);
    #5 prog_wr_o.en = 1'b0;
  endtask
endmodule

/* bench/testbench.sv */
// self-checking bench of the angle-to-code mapper
// assumes acm_pkg compiled first; programming tool model drives the write port
`timescale 1ns/1ns
module testbench;
  import acm_pkg::*;
  logic         sys_clk_i;
  logic         rst_b_i;
  acm_prog_wr_t prog_wr;
  logic [3:0]   rd_addr;
  logic [15:0]  rd_data;
  logic [15:0]  angle;
  logic         angle_valid;
  logic [12:0]  dac_code;
  logic         dac_valid;
  int           fail_count;
  int           check_count;
  int           i;
  // readback address and word after reset
  logic [19:0]  rst_rows [7] = '{20'h7_0000, 20'h9_2000, 20'hA_0100, 20'hB_12FF,
                                 20'hE_FFC1, 20'hF_0000, 20'h3_0000};
  // default gain 0.5625, limits 256..4863, switch at 3FFh
  logic [28:0]  ang_rows [4] = '{{16'h0000, 13'h0100}, {16'h4000, 13'h0580},
                                 {16'h8000, 13'h0A00}, {16'hFFFF, 13'h12FF}};

  acm_prog_model prog (.sys_clk_i(sys_clk_i), .prog_wr_o(prog_wr));
  acm_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .prog_wr_i(prog_wr),
    .prog_rd_addr_i(rd_addr), .prog_rd_data_o(rd_data), .angle_i(angle),
    .angle_valid_i(angle_valid), .dac_code_o(dac_code), .dac_valid_o(dac_valid));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    #5 rd_addr = a;
    @(posedge sys_clk_i);
    #5 check("readback", exp, rd_data);
  endtask

  task automatic send(input logic [15:0] a, input logic [12:0] exp);
    int n;
    @(posedge sys_clk_i);
    #5 angle = a;
    angle_valid = 1'b1;
    @(posedge sys_clk_i);
    #5 angle_valid = 1'b0;
    n = 1;
    while (dac_valid !== 1'b1 && n < 10) begin
      @(posedge sys_clk_i);
      #5 n++;
    end
    if (n >= 10) begin
      fail_count++;
      end_of_test();
    end
    check("latency", 16'(3), 16'(n));
    check("code", {3'h0, exp}, {3'h0, dac_code});
    @(posedge sys_clk_i);
    #5 check("valid pulse", 16'h0000, {15'h0, dac_valid});
  endtask

  task automatic reset_and_readback();
    rst_b_i = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    #5 check("reset code", 16'h0100, {3'h0, dac_code});
    check("reset valid", 16'h0000, {15'h0, dac_valid});
    check("reset readback", 16'h0000, rd_data);
    rst_b_i = 1'b1;
    for (i = 0; i < 7; i++) read(rst_rows[i][19:16], rst_rows[i][15:0]);
    $display("test reset readback done");
  endtask

  initial begin
    fail_count = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    rd_addr = 4'h0;
    angle = 16'h0000;
    angle_valid = 1'b0;
    reset_and_readback();
    for (i = 0; i < 4; i++) send(ang_rows[i][28:13], ang_rows[i][12:0]);
    $display("test default mapping done");
    // limits 512..4608, gain 1.125, switch at 90 degrees
    prog.write(4'hA, 16'h0200);
    prog.write(4'hB, 16'h1200);
    prog.write(4'h9, 16'h4000);
    prog.write(4'hE, 16'h8002);
    prog.write(4'h3, 16'h5555);
    read(4'hA, 16'h0200);
    read(4'hB, 16'h1200);
    read(4'h9, 16'h4000);
    read(4'hE, 16'h8002);
    read(4'h3, 16'h0000);
    send(16'h4000, 13'h0B00);
    send(16'h7FC0, 13'h1200);
    send(16'h8040, 13'h0200);
    $display("test programmed rising done");
    prog.write(4'h7, 16'h1000);
    send(16'h5000, 13'h0B00);
    send(16'h0800, 13'h0200);
    @(posedge sys_clk_i);
    #5 angle = 16'h5000;
    angle_valid = 1'b1;
    @(posedge sys_clk_i);
    #5 angle = 16'h9040;
    @(posedge sys_clk_i);
    #5 angle_valid = 1'b0;
    @(posedge sys_clk_i);
    #5 check("first of pair", 16'h8B00, {dac_valid, 2'h0, dac_code});
    @(posedge sys_clk_i);
    #5 check("second of pair", 16'h8200, {dac_valid, 2'h0, dac_code});
    $display("test zero angle and back to back done");
    prog.write(4'hF, 16'h0100);
    read(4'hF, 16'h0100);
    send(16'h5000, 13'h0900);
    send(16'h8FC0, 13'h0200);
    send(16'h9040, 13'h1200);
    $display("test falling slope done");
    reset_and_readback();
    send(16'h4000, 13'h0580);
    $display("test second reset done");
    end_of_test();
  end
endmodule

/* logic/acm_mult.sv */
// registered unsigned multiplier: angle offset by range gain
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ns
module acm_mult
  import acm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] offset_i,
  input  wire logic [18:0] gain_i,
  output logic      [34:0] prod_o
);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prod_o <= 35'h0_0000_0000;
    end else begin
      // both operands widened so the product keeps all 35 bits
      prod_o <= {19'h0_0000, offset_i} * {16'h0000, gain_i};
    end
  end
endmodule

/* logic/acm_params.svh */
// offsets, field positions, reset values and latencies of the angle-to-code mapper
// assumes inclusion by bare name from the package only; the mapper modules do not include it
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH

`define ACM_ADDR_ZERO_ANGLE   4'h7
`define ACM_ADDR_GAIN_LOW     4'h9
`define ACM_ADDR_LOWER_LIMIT  4'hA
`define ACM_ADDR_UPPER_LIMIT  4'hB
`define ACM_ADDR_SW_GAIN_HIGH 4'hE
`define ACM_ADDR_CUST_CTRL    4'hF

`define ACM_GAIN_LOW_MSB      15
`define ACM_GAIN_LOW_LSB      3
`define ACM_LIMIT_MSB         12
`define ACM_SW_ANGLE_MSB      15
`define ACM_SW_ANGLE_LSB      6
`define ACM_GAIN_HIGH_MSB     5
`define ACM_SLOPE_BIT         8

`define ACM_RST_ZERO_ANGLE    16'h0000
`define ACM_RST_GAIN_LOW      16'h2000
`define ACM_RST_LOWER_LIMIT   16'h0100
`define ACM_RST_UPPER_LIMIT   16'h12FF
`define ACM_RST_SW_GAIN_HIGH  16'hFFC1

// product keeps 14 gain fraction bits; code = offset * gain * 8192 / 65536
`define ACM_PROD_SHIFT        17
`define ACM_PIPE_LATENCY      3

`endif

/* logic/acm_pkg.sv */
// types shared by the angle-to-code mapper
// assumes acm_params.svh on the include path
package acm_pkg;
  `include "acm_params.svh"

  typedef enum logic {
    ACM_SLOPE_RISE = 1'b0,
    ACM_SLOPE_FALL = 1'b1
  } acm_slope_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  addr;
    logic [15:0] data;
  } acm_prog_wr_t;

  typedef struct packed {
    logic [12:0] lo;
    logic [12:0] hi;
  } acm_limits_t;
endpackage

/* logic/acm_top.sv */
// angle-to-output mapper: stored words, gain, wrap switch and limit clamp
// assumes angle words from the same-clock angle path and word writes
// from the programming-pin decoder; output code feeds the converter
//
// Contract
// - low gain word 9h bits 15..3 weigh 2^-2 down to 2^-14
// - unused stored bits written zero; readback of them arbitrary
// - word Ah bits 12..0 give lower limit code, valid 256..4864
// - word Bh bits 12..0 give upper limit code, one count per bit
// - word Eh bits 5..0 are gain high part, joined above low part
// - word Eh bits 15..6 are switch angle, fraction of half turn
// - rising slope and angle above switch angle drives lower limit
// - control bit 8 selects slope: 0 rising, 1 falling
`timescale 1ns/1ns
module acm_top
  import acm_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire acm_prog_wr_t prog_wr_i,
  input  wire logic [3:0]   prog_rd_addr_i,
  output logic      [15:0]  prog_rd_data_o,
  input  wire logic [15:0]  angle_i,
  input  wire logic         angle_valid_i,
  output logic      [12:0]  dac_code_o,
  output logic              dac_valid_o
);
  logic [15:0] zero_angle_reg;
  logic [12:0] gain_low_reg;
  logic [5:0]  gain_high_reg;
  logic [9:0]  sw_angle_reg;
  acm_limits_t limits_reg;
  acm_slope_t  slope_reg;

  logic        wr_zero;
  logic        wr_gain_low;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_sw;
  logic        wr_ctrl;

  function automatic logic hit(input acm_prog_wr_t w, input logic [3:0] a);
    hit = w.en && (w.addr == a);
  endfunction

  assign wr_zero     = hit(prog_wr_i, `ACM_ADDR_ZERO_ANGLE);
  assign wr_gain_low = hit(prog_wr_i, `ACM_ADDR_GAIN_LOW);
  assign wr_lo       = hit(prog_wr_i, `ACM_ADDR_LOWER_LIMIT);
  assign wr_hi       = hit(prog_wr_i, `ACM_ADDR_UPPER_LIMIT);
  assign wr_sw       = hit(prog_wr_i, `ACM_ADDR_SW_GAIN_HIGH);
  assign wr_ctrl     = hit(prog_wr_i, `ACM_ADDR_CUST_CTRL);

  // stored words
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      zero_angle_reg <= `ACM_RST_ZERO_ANGLE;
    end else if (wr_zero) begin
      zero_angle_reg <= prog_wr_i.data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      gain_low_reg <= 13'(`ACM_RST_GAIN_LOW >> `ACM_GAIN_LOW_LSB);
    end else if (wr_gain_low) begin
      gain_low_reg <= prog_wr_i.data[`ACM_GAIN_LOW_MSB:`ACM_GAIN_LOW_LSB];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      limits_reg.lo <= 13'(`ACM_RST_LOWER_LIMIT);
      limits_reg.hi <= 13'(`ACM_RST_UPPER_LIMIT);
    end else begin
      if (wr_lo) begin
        limits_reg.lo <= prog_wr_i.data[`ACM_LIMIT_MSB:0];
      end
      if (wr_hi) begin
        limits_reg.hi <= prog_wr_i.data[`ACM_LIMIT_MSB:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sw_angle_reg  <= 10'(`ACM_RST_SW_GAIN_HIGH >> `ACM_SW_ANGLE_LSB);
      gain_high_reg <= 6'(`ACM_RST_SW_GAIN_HIGH);
    end else if (wr_sw) begin
      sw_angle_reg  <= prog_wr_i.data[`ACM_SW_ANGLE_MSB:`ACM_SW_ANGLE_LSB];
      gain_high_reg <= prog_wr_i.data[`ACM_GAIN_HIGH_MSB:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      slope_reg <= ACM_SLOPE_RISE;
    end else if (wr_ctrl) begin
      slope_reg <= acm_slope_t'(prog_wr_i.data[`ACM_SLOPE_BIT]);
    end
  end

  // readback; unused bits return zero
  logic [15:0] rd_next;
  always_comb begin
    rd_next = 16'h0000;
    unique case (prog_rd_addr_i)
      `ACM_ADDR_ZERO_ANGLE:   rd_next = zero_angle_reg;
      `ACM_ADDR_GAIN_LOW:     rd_next = {gain_low_reg, 3'h0};
      `ACM_ADDR_LOWER_LIMIT:  rd_next = {3'h0, limits_reg.lo};
      `ACM_ADDR_UPPER_LIMIT:  rd_next = {3'h0, limits_reg.hi};
      `ACM_ADDR_SW_GAIN_HIGH: rd_next = {sw_angle_reg, gain_high_reg};
      `ACM_ADDR_CUST_CTRL:    rd_next = {7'h00, slope_reg, 8'h00};
      default:                rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prog_rd_data_o <= 16'h0000;
    end else begin
      prog_rd_data_o <= rd_next;
    end
  end

  // stage 1: offset from zero angle, settings snapshot
  logic [15:0] offset_reg;
  logic        v1_reg;
  logic        v2_reg;
  logic        over1_reg;
  logic        over2_reg;
  acm_limits_t lim1_reg;
  acm_limits_t lim2_reg;
  acm_slope_t  slope1_reg;
  acm_slope_t  slope2_reg;
  logic [15:0] offset_next;

  assign offset_next = angle_i - zero_angle_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      offset_reg <= 16'h0000;
      over1_reg  <= 1'b0;
      lim1_reg   <= '0;
      slope1_reg <= ACM_SLOPE_RISE;
    end else if (angle_valid_i) begin
      offset_reg <= offset_next;
      over1_reg  <= offset_next[15:6] > sw_angle_reg;
      lim1_reg   <= limits_reg;
      slope1_reg <= slope_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      v1_reg <= 1'b0;
      v2_reg <= 1'b0;
    end else begin
      v1_reg <= angle_valid_i;
      v2_reg <= v1_reg;
    end
  end

  // stage 2: product of offset and joined gain
  logic [34:0] prod;

  acm_mult u_mult (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .offset_i  (offset_reg),
    .gain_i    ({gain_high_reg, gain_low_reg}),
    .prod_o    (prod)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      over2_reg  <= 1'b0;
      lim2_reg   <= '0;
      slope2_reg <= ACM_SLOPE_RISE;
    end else if (v1_reg) begin
      over2_reg  <= over1_reg;
      lim2_reg   <= lim1_reg;
      slope2_reg <= slope1_reg;
    end
  end

  // stage 3: slope, wrap switch, clamp
  logic [17:0] delta;
  logic [18:0] span;
  logic [18:0] rise_sum;
  logic [12:0] code_next;

  assign delta    = prod[34:`ACM_PROD_SHIFT];
  assign span     = {6'h00, lim2_reg.hi} - {6'h00, lim2_reg.lo};
  assign rise_sum = {6'h00, lim2_reg.lo} + {1'b0, delta};

  always_comb begin
    code_next = lim2_reg.lo;
    if (slope2_reg == ACM_SLOPE_RISE && over2_reg) begin
      code_next = lim2_reg.lo;
    end else if (slope2_reg == ACM_SLOPE_FALL && over2_reg) begin
      code_next = lim2_reg.hi;
    end else if ({1'b0, delta} >= span) begin
      code_next = (slope2_reg == ACM_SLOPE_RISE) ? lim2_reg.hi : lim2_reg.lo;
    end else if (slope2_reg == ACM_SLOPE_RISE) begin
      code_next = rise_sum[12:0];
    end else begin
      code_next = 13'(lim2_reg.hi - delta[12:0]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dac_code_o  <= 13'(`ACM_RST_LOWER_LIMIT);
      dac_valid_o <= 1'b0;
    end else begin
      dac_valid_o <= v2_reg;
      if (v2_reg) begin
        dac_code_o <= code_next;
      end
    end
  end

  // checks
  chk_code_above_lo: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    v2_reg && lim2_reg.lo <= lim2_reg.hi |=> dac_code_o >= $past(lim2_reg.lo))
    else $error("output code below lower limit");

  chk_code_below_hi: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    v2_reg && lim2_reg.lo <= lim2_reg.hi |=> dac_code_o <= $past(lim2_reg.hi))
    else $error("output code above upper limit");

  chk_wrap_to_lo: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    angle_valid_i && slope_reg == ACM_SLOPE_RISE
      && (offset_next[15:6] > sw_angle_reg) && !wr_lo
      |-> ##3 dac_code_o == $past(limits_reg.lo, 3))
    else $error("rising slope past switch angle did not give lower limit");

  chk_pipe_latency: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    angle_valid_i |-> ##3 dac_valid_o)
    else $error("output valid not three cycles after angle valid");

  chk_slope_store: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_ctrl |=> slope_reg == acm_slope_t'($past(prog_wr_i.data[8])))
    else $error("slope bit not stored");

  chk_gain_low_store: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_gain_low |=> gain_low_reg == $past(prog_wr_i.data[`ACM_GAIN_LOW_MSB:`ACM_GAIN_LOW_LSB]))
    else $error("low gain word not stored from bits 15 to 3");

  chk_limit_store: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_lo && !wr_hi |=> limits_reg.lo == $past(prog_wr_i.data[12:0])
      && $stable(limits_reg.hi))
    else $error("lower limit write not stored");

  chk_sw_gain_split: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_sw |=> {sw_angle_reg, gain_high_reg} == $past(prog_wr_i.data))
    else $error("switch angle and high gain split wrong");

  chk_fall_gain_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    v2_reg && slope2_reg == ACM_SLOPE_FALL && !over2_reg && delta == 18'h0_0000
      && lim2_reg.lo < lim2_reg.hi |=> dac_code_o == $past(lim2_reg.hi))
    else $error("falling slope at zero offset not at upper limit");
endmodule
